// [shared/pld_params.svh]
// Offsets, field positions, reset values and scaling constants of the lock detector
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// Register offsets on the plain register port
`define PLD_CFG_OFS 8'h00
`define PLD_STATUS_OFS 8'h04
`define PLD_IRQ_STATUS_OFS 8'h08
`define PLD_IRQ_MASK_OFS 8'h0C

// Reset values
`define PLD_CFG_RST 15'h0000
`define PLD_IRQ_MASK_RST 2'h0

// Field positions in the configuration and status words
`define PLD_MODE_BIT 14
`define PLD_STATUS_LOCK_BIT 7

// Interrupt status bit positions
`define PLD_IRQ_GAIN_BIT 0
`define PLD_IRQ_LOSS_BIT 1

// Integrator scaling: full scale, hysteresis thresholds and base charge step
`define PLD_INTEG_MAX 20'hFFFFF
`define PLD_INTEG_UPPER 20'hC0000
`define PLD_INTEG_LOWER 20'h40000
`define PLD_CHARGE_BASE 20'h00800

`endif

// [shared/pld_pkg.sv]
// Types shared by the lock detector design
package pld_pkg;

    // Configuration word split into its fields (digital and integrating views overlap)
    typedef struct packed {
        logic       mode;         // 0 digital, 1 integrating
        logic       rsvd;         // Reserved bit 13
        logic [1:0] loss_mult;    // Window widening while locked
        logic [2:0] lock_window;  // Base error window width
        logic [2:0] loss_thresh;  // Consecutive misses to drop lock
        logic [4:0] lock_thresh;  // Consecutive hits to gain lock
    } pld_cfg_s;

    // Phase comparison tracker
    typedef enum logic [1:0] {
        PLD_PH_IDLE,
        PLD_PH_REF_FIRST,
        PLD_PH_FB_FIRST
    } pld_phase_e;

endpackage

// [hw/pld_lock_detector.sv]
// Lock detector comparing reference and feedback divider clocks, with register port
`include "pld_params.svh"

// Operation
// - Bit 14 clear selects digital detection
// - Phase error: time between rising edges
// - In-window or miss pulse per comparison
// - Lock after threshold consecutive in-window pulses
// - Unlock after loss threshold consecutive misses
// - Unlocked: window from lock window field
// - Locked: window widened by multiplier field
// - Bit 14 set selects integrating detection
// - Error pulse: first edge to other edge
// - Integrator rises when pulse low, falls high
// - Lock above upper, unlock below lower
// - Bits 3-0 set charge rate
// - Bits 6-4 set larger discharge rate
// - Lock level visible in status register
// - Status lock bit readable any time
module pld_lock_detector #(
    parameter int ERR_W = 8,   // Width of the phase error counter
    parameter int RUN_W = 5,   // Width of the run counters
    parameter int INTEG_W = 20 // Width of the integrator
) (
    input wire logic sys_clk,        // System clock, 50 MHz
    input wire logic rst,            // Synchronous reset, active high
    input wire logic ref_div_clk,    // Reference divider output, asynchronous
    input wire logic fb_div_clk,     // Feedback divider output, asynchronous
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [15:0] reg_wdata, // Register write data
    input wire logic reg_wr,         // Write strobe
    input wire logic reg_rd,         // Read strobe
    output logic [15:0] reg_rdata,   // Read data, valid the cycle after reg_rd
    output logic lock_out,           // Lock level
    output logic irq                 // Level interrupt
);

    // Divider clock synchronisers; stage one feeds only stage two
    logic ref_s1, ref_s2, ref_s3;
    logic fb_s1, fb_s2, fb_s3;
    logic ref_rise, fb_rise;

    // Software state
    logic [14:0] cfg_word, next_cfg_word;       // Configuration word
    logic [1:0] irq_status, next_irq_status;    // Sticky events
    logic [1:0] irq_mask, next_irq_mask;        // Interrupt enables
    logic [15:0] next_reg_rdata;                // Read data to register
    logic next_irq;                             // Interrupt to register
    pld_pkg::pld_cfg_s cfg;                     // Field view of cfg_word

    // Detector state
    pld_pkg::pld_phase_e ph, next_ph;           // Comparison tracker
    logic [ERR_W-1:0] err_cnt, next_err_cnt;    // Cycles since first edge
    logic [RUN_W-1:0] in_run, next_in_run;      // Consecutive in-window pulses
    logic [RUN_W-1:0] out_run, next_out_run;    // Consecutive misses
    logic [INTEG_W-1:0] integ, next_integ;      // Capacitor model
    logic next_lock;                            // Lock level to register
    logic in_window_pulse;                      // One-cycle hit
    logic window_miss_pulse;                    // One-cycle miss
    logic phase_err_high;                       // Integrating error pulse
    logic [ERR_W-1:0] win;                      // Current error window
    logic [INTEG_W-1:0] charge_step;            // Integrator rise per cycle
    logic [INTEG_W-1:0] discharge_step;         // Integrator fall per cycle

    assign cfg = pld_pkg::pld_cfg_s'(cfg_word);

    // Edge detection reads stages two and three only
    assign ref_rise = ref_s2 & ~ref_s3;
    assign fb_rise = fb_s2 & ~fb_s3;

    // Synchroniser chain, no reset needed for metastability stages
    always_ff @(posedge sys_clk)
    begin
        ref_s1 <= ref_div_clk;
        ref_s2 <= ref_s1;
        ref_s3 <= ref_s2;
        fb_s1 <= fb_div_clk;
        fb_s2 <= fb_s1;
        fb_s3 <= fb_s2;
    end

    // Threshold of zero is treated as one so lock can never be instant
    function automatic logic [RUN_W:0] thresh_min1(input logic [RUN_W-1:0] t);
        thresh_min1 = (t == '0) ? (RUN_W+1)'(1) : {1'b0, t};
    endfunction

    // Window width: base field plus one, shifted by the multiplier while locked
    always_comb
    begin
        win = ERR_W'({1'b0, cfg.lock_window} + 4'h1);
        if (lock_out)
        begin
            win = win << cfg.loss_mult;
        end
    end

    // Integrator steps: a larger charge field up to 11 means a slower rise to the upper level; fields 11 to 15 all give a step of one
    always_comb
    begin
        charge_step = `PLD_CHARGE_BASE >> cfg_word[3:0];
        if (charge_step == '0)
        begin
            charge_step = INTEG_W'(1);
        end
        // Multiplier of field plus two keeps discharge strictly faster
        discharge_step = INTEG_W'(charge_step * ({2'h0, cfg_word[6:4]} + 5'h2));
    end

    // Phase tracker: the first edge opens a comparison, the other edge closes it
    always_comb
    begin
        logic other_rise;
        logic same_rise;
        other_rise = 1'b0;
        same_rise = 1'b0;
        next_ph = ph;
        next_err_cnt = err_cnt;
        in_window_pulse = 1'b0;
        window_miss_pulse = 1'b0;
        case (ph)
            pld_pkg::PLD_PH_IDLE:
            begin
                next_err_cnt = '0;
                if (ref_rise && fb_rise)
                begin
                    in_window_pulse = 1'b1;
                end
                else if (ref_rise)
                begin
                    next_ph = pld_pkg::PLD_PH_REF_FIRST;
                end
                else if (fb_rise)
                begin
                    next_ph = pld_pkg::PLD_PH_FB_FIRST;
                end
            end
            pld_pkg::PLD_PH_REF_FIRST, pld_pkg::PLD_PH_FB_FIRST:
            begin
                other_rise = (ph == pld_pkg::PLD_PH_REF_FIRST) ? fb_rise : ref_rise;
                same_rise = (ph == pld_pkg::PLD_PH_REF_FIRST) ? ref_rise : fb_rise;
                if (other_rise)
                begin
                    // Error measured in system clock cycles
                    in_window_pulse = (err_cnt < win);
                    window_miss_pulse = (err_cnt >= win);
                    next_err_cnt = '0;
                    next_ph = same_rise ? ph : pld_pkg::PLD_PH_IDLE;
                end
                else if (same_rise)
                begin
                    // A whole period passed with no partner edge: a clear miss
                    window_miss_pulse = 1'b1;
                    next_err_cnt = '0;
                end
                else if (err_cnt != '1)
                begin
                    next_err_cnt = err_cnt + ERR_W'(1);
                end
            end
            default:
            begin
                next_ph = pld_pkg::PLD_PH_IDLE;
                next_err_cnt = '0;
            end
        endcase
    end

    // Error pulse for the integrating method is high while a comparison is open
    assign phase_err_high = (ph != pld_pkg::PLD_PH_IDLE);

    // Lock decision for both methods
    always_comb
    begin
        next_lock = lock_out;
        next_in_run = in_run;
        next_out_run = out_run;
        next_integ = integ;
        if (!cfg.mode)
        begin
            // Digital method
            if (in_window_pulse)
            begin
                next_out_run = '0;
                if (in_run != '1)
                begin
                    next_in_run = in_run + RUN_W'(1);
                end
                if (!lock_out && ({1'b0, in_run} + 1'b1 >= thresh_min1(cfg.lock_thresh)))
                begin
                    next_lock = 1'b1;
                end
            end
            else if (window_miss_pulse)
            begin
                next_in_run = '0;
                if (out_run != '1)
                begin
                    next_out_run = out_run + RUN_W'(1);
                end
                if (lock_out && ({1'b0, out_run} + 1'b1 >=
                    thresh_min1(RUN_W'(cfg.loss_thresh))))
                begin
                    next_lock = 1'b0;
                end
            end
        end
        else
        begin
            // Integrating method with saturating accumulator
            if (!phase_err_high)
            begin
                next_integ = (integ > `PLD_INTEG_MAX - charge_step) ?
                    `PLD_INTEG_MAX : integ + charge_step;
            end
            else
            begin
                next_integ = (integ < discharge_step) ?
                    '0 : integ - discharge_step;
            end
            // Hysteresis between the two thresholds
            if (integ > `PLD_INTEG_UPPER)
            begin
                next_lock = 1'b1;
            end
            else if (integ < `PLD_INTEG_LOWER)
            begin
                next_lock = 1'b0;
            end
        end
    end

    // Register port: writes, sticky events, interrupt and registered read data
    always_comb
    begin
        logic [1:0] events;
        logic [1:0] clr;
        events = '0;
        clr = '0;
        next_cfg_word = cfg_word;
        next_irq_mask = irq_mask;
        next_reg_rdata = '0;
        events[`PLD_IRQ_GAIN_BIT] = next_lock & ~lock_out;
        events[`PLD_IRQ_LOSS_BIT] = ~next_lock & lock_out;
        if (reg_wr)
        begin
            case (reg_addr)
                `PLD_CFG_OFS: next_cfg_word = reg_wdata[14:0];
                `PLD_IRQ_STATUS_OFS: clr = reg_wdata[1:0];
                `PLD_IRQ_MASK_OFS: next_irq_mask = reg_wdata[1:0];
                default: ; // Unmapped writes are dropped
            endcase
        end
        // A new event beats a clear in the same cycle
        next_irq_status = (irq_status & ~clr) | events;
        next_irq = |(next_irq_status & next_irq_mask);
        if (reg_rd)
        begin
            case (reg_addr)
                `PLD_CFG_OFS: next_reg_rdata = {1'b0, cfg_word};
                `PLD_STATUS_OFS: next_reg_rdata[`PLD_STATUS_LOCK_BIT] = lock_out;
                `PLD_IRQ_STATUS_OFS: next_reg_rdata = {14'h0, irq_status};
                `PLD_IRQ_MASK_OFS: next_reg_rdata = {14'h0, irq_mask};
                default: next_reg_rdata = '0; // Unmapped reads return zero
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ph <= pld_pkg::PLD_PH_IDLE;
            err_cnt <= '0;
            in_run <= '0;
            out_run <= '0;
            integ <= '0;
            lock_out <= 1'b0;
            cfg_word <= `PLD_CFG_RST;
            irq_status <= '0;
            irq_mask <= `PLD_IRQ_MASK_RST;
            irq <= 1'b0;
            reg_rdata <= '0;
        end
        else
        begin
            ph <= next_ph;
            err_cnt <= next_err_cnt;
            in_run <= next_in_run;
            out_run <= next_out_run;
            integ <= next_integ;
            lock_out <= next_lock;
            cfg_word <= next_cfg_word;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Checks on the design's own behaviour
    default clocking cb @(posedge sys_clk); endclocking

    lock_gain_digital_a: assert property (disable iff (rst)
        (!cfg.mode && !lock_out && in_window_pulse &&
        ({1'b0, in_run} + 1'b1 >= thresh_min1(cfg.lock_thresh))) |=> lock_out)
        else $error("lock not raised at threshold");

    lock_loss_digital_a: assert property (disable iff (rst)
        (!cfg.mode && lock_out && window_miss_pulse && !reg_wr &&
        ({1'b0, out_run} + 1'b1 >= thresh_min1(RUN_W'(cfg.loss_thresh)))) |=> !lock_out)
        else $error("lock not dropped at loss threshold");

    run_clear_a: assert property (disable iff (rst)
        (!cfg.mode && window_miss_pulse) |=> (in_run == '0))
        else $error("hit run not cleared by miss");

    window_hit_a: assert property (disable iff (rst)
        in_window_pulse |-> (ph == pld_pkg::PLD_PH_IDLE || err_cnt < win))
        else $error("hit reported outside window");

    integ_charge_a: assert property (disable iff (rst)
        (cfg.mode && !phase_err_high && !reg_wr) |=> (integ >= $past(integ)))
        else $error("integrator fell while charging");

    integ_lock_a: assert property (disable iff (rst)
        (cfg.mode && integ > `PLD_INTEG_UPPER) |=> lock_out)
        else $error("lock not raised above upper level");

    status_read_a: assert property (disable iff (rst)
        (reg_rd && reg_addr == `PLD_STATUS_OFS) |=>
        (reg_rdata[`PLD_STATUS_LOCK_BIT] == $past(lock_out)))
        else $error("status lock bit wrong");

    reset_clear_a: assert property (
        rst |=> (!lock_out && integ == '0 && in_run == '0 && out_run == '0))
        else $error("reset left state behind");

endmodule

// [test/pld_div_model.sv]
// Behavioural reference and feedback divider clock pair with a programmable lag
module pld_div_model #(
    parameter int PERIOD = 32 // Comparison period in sys_clk cycles
) (
    input wire logic sys_clk,     // System clock
    input wire logic run,         // Clocks toggle only while high
    input wire logic [7:0] skew,  // Feedback lag behind reference, in cycles
    output logic ref_div_clk,     // Reference divider clock
    output logic fb_div_clk       // Feedback divider clock
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0; // Position inside the period

    // Both clocks stand low at time zero and while stopped
    initial
    begin
        ref_div_clk = 1'b0;
        fb_div_clk = 1'b0;
    end

    // A skew of zero gives coincident edges; a large skew lands outside the window
    always @(posedge sys_clk)
    begin
        cnt <= run ? (cnt + 1) % PERIOD : 0;
        ref_div_clk <= run && cnt < PERIOD / 4;
        fb_div_clk <= run && cnt >= skew && cnt < skew + PERIOD / 4;
    end
endmodule

// [test/testbench.sv]
// Self-checking bench for the lock detector: register port, digital and integrating modes
`include "pld_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0; // 50 MHz clock
    logic rst = 1'b1; // Synchronous reset
    logic [7:0] reg_addr = 8'h00; // Register address
    logic [15:0] reg_wdata = 16'h0000; // Write data
    logic reg_wr = 1'b0; // Write strobe
    logic reg_rd = 1'b0; // Read strobe
    logic [15:0] reg_rdata; // Read data
    logic lock_out; // Lock level
    logic irq; // Interrupt level
    logic ref_div_clk; // Reference divider clock
    logic fb_div_clk; // Feedback divider clock
    logic run = 1'b0; // Divider clocks running
    logic [7:0] skew = 8'h00; // Feedback lag in cycles
    logic [15:0] rd; // Last read word
    int n; // Cycles waited
    int num_errors = 0;
    int n_checks = 0;

    // Clock: 20 ns period
    always #10 sys_clk = ~sys_clk;

    pld_lock_detector u_dut (.sys_clk(sys_clk), .rst(rst), .ref_div_clk(ref_div_clk),
        .fb_div_clk(fb_div_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_out(lock_out),
        .irq(irq));

    pld_div_model u_div (.sys_clk(sys_clk), .run(run), .skew(skew),
        .ref_div_clk(ref_div_clk), .fb_div_clk(fb_div_clk));

    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read strobe; data stands only in the following cycle
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Bounded wait for a lock level; n returns the cycles spent
    task automatic wait_lock(input logic lvl, input int limit, output int cnt);
        cnt = 0;
        while (lock_out !== lvl && cnt < limit)
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask

    // Reset values, read-only and unmapped places
    task automatic test_regs;
        check("lock after reset", lock_out, 1'b0);
        check("irq after reset", irq, 1'b0);
        reg_read(`PLD_CFG_OFS, rd);
        check("cfg reset", rd, 16'(`PLD_CFG_RST));
        reg_write(`PLD_CFG_OFS, 16'hFFFF);
        reg_read(`PLD_CFG_OFS, rd);
        check("cfg width", rd, 16'h7FFF);
        reg_write(`PLD_STATUS_OFS, 16'hFFFF);
        reg_read(`PLD_STATUS_OFS, rd);
        check("status read only", rd, 16'h0000);
        reg_read(8'h10, rd);
        check("unmapped read", rd, 16'h0000);
        reg_read(`PLD_IRQ_MASK_OFS, rd);
        check("mask reset", rd, 16'h0000);
        $display("test_regs done");
    endtask

    // Digital mode: lock after four hits, interrupt raise, mask, clear
    task automatic test_digital;
        // Lock 4, loss 2, window 2, multiplier 2; thresholds above one resist noise
        reg_write(`PLD_CFG_OFS, 16'h1244);
        @(posedge sys_clk);
        skew <= 8'h01;
        run <= 1'b1;
        wait_lock(1'b1, 400, n);
        check("lock time", n >= 90 && n <= 125, 1'b1);
        reg_read(`PLD_STATUS_OFS, rd);
        check("status lock", rd & 16'h0080, 16'h0080);
        reg_read(`PLD_IRQ_STATUS_OFS, rd);
        check("gain event", rd, 16'h0001);
        check("irq masked", irq, 1'b0);
        reg_write(`PLD_IRQ_MASK_OFS, 16'h0001);
        check("irq unmasked", irq, 1'b1);
        reg_write(`PLD_IRQ_STATUS_OFS, 16'h0001);
        check("irq cleared", irq, 1'b0);
        $display("test_digital done");
    endtask

    // Widened window while locked, loss of lock, base window while unlocked
    task automatic test_window;
        @(posedge sys_clk);
        skew <= 8'h06;
        wait_lock(1'b0, 200, n);
        check("wide window holds", n, 16'd200);
        @(posedge sys_clk);
        // Half a period of lag misses the widened window whichever edge opens the comparison
        skew <= 8'h10;
        wait_lock(1'b0, 150, n);
        check("loss of lock", lock_out, 1'b0);
        reg_read(`PLD_IRQ_STATUS_OFS, rd);
        check("loss event", rd, 16'h0002);
        check("loss masked", irq, 1'b0);
        @(posedge sys_clk);
        skew <= 8'h06;
        wait_lock(1'b1, 300, n);
        check("base window misses", n, 16'd300);
        reg_read(`PLD_STATUS_OFS, rd);
        check("status unlock", rd & 16'h0080, 16'h0000);
        $display("test_window done");
    endtask

    // Integrating mode after a second reset: charge up, hysteresis, discharge
    task automatic test_integ;
        @(posedge sys_clk);
        rst <= 1'b1;
        skew <= 8'h01;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check("lock second reset", lock_out, 1'b0);
        reg_write(`PLD_CFG_OFS, 16'h4000);
        wait_lock(1'b1, 1000, n);
        check("charge time", n >= 300 && n <= 700, 1'b1);
        @(posedge sys_clk);
        skew <= 8'h10;
        wait_lock(1'b0, 100, n);
        check("hysteresis", n, 16'd100);
        wait_lock(1'b0, 1500, n);
        check("discharge", lock_out, 1'b0);
        $display("test_integ done");
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        test_regs();
        test_digital();
        test_window();
        test_integ();
        final_report();
    end

    // Watchdog: the tests need well under 6000 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end
endmodule
